// file: rtl/adm_map.vh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * ADC diagnostic error monitor.
 * Assumes a byte-addressed register port with 32-bit words on aligned offsets.
 */
`ifndef ADM_MAP_VH
`define ADM_MAP_VH

// Register byte offsets
`define ADM_ADDR_W 8
`define ADM_OFF_ERR_EN 8'h00
`define ADM_OFF_ERR_FLAGS 8'h04
`define ADM_OFF_STATUS 8'h08
`define ADM_OFF_CLK_COUNT 8'h0c
`define ADM_OFF_CHAN_SEL 8'h10
`define ADM_OFF_OFFSET 8'h14
`define ADM_OFF_GAIN 8'h18
`define ADM_OFF_DATA 8'h1c
`define ADM_STAT_SUMMARY 0
`define ADM_WORD_ZERO 32'h00000000

// Enable register fields
`define ADM_EN_W 6
`define ADM_EN_REF_LOSS 0
`define ADM_EN_CONV 1
`define ADM_EN_POS_IN 2
`define ADM_EN_NEG_IN 3
`define ADM_EN_REF_RANGE 4
`define ADM_EN_CLK_COUNT 5
`define ADM_EN_RESET 6'h00

// Error flag register fields
`define ADM_FLAG_W 5
`define ADM_FLAG_REF_LOSS 0
`define ADM_FLAG_CONV 1
`define ADM_FLAG_POS_IN 2
`define ADM_FLAG_NEG_IN 3
`define ADM_FLAG_REF_RANGE 4
`define ADM_FLAG_RESET 5'h00

// Channel select register: input code in bits 1:0, external reference in bit 4
`define ADM_SEL_CODE_HI 1
`define ADM_SEL_CODE_LO 0
`define ADM_SEL_EXT_REF 4
`define ADM_SEL_W 5
`define ADM_SEL_RESET 5'h00
`define ADM_CODE_NORMAL 2'h0
`define ADM_CODE_AVDD 2'h1
`define ADM_CODE_IOVDD 2'h2
`define ADM_CODE_TEST 2'h3

// Data path widths, limits and resets
`define ADM_DATA_W 24
`define ADM_DATA_ZERO 24'h000000
`define ADM_DATA_ONES 24'hffffff
`define ADM_OFFSET_MIN 24'h07ffff
`define ADM_OFFSET_MAX 24'hf7ffff
`define ADM_OFFSET_RESET 24'h800000
`define ADM_GAIN_RESET 24'h555555

// Modulator saturation run length
`define ADM_RUN_W 5
`define ADM_RUN_LIMIT 5'h14
`define ADM_RUN_ONE 5'h01
`define ADM_RUN_ZERO 5'h00

// Controller clock counter
`define ADM_CLK_DIV_W 8
`define ADM_CLK_DIV_LAST 8'h82
`define ADM_CLK_DIV_ZERO 8'h00
`define ADM_CLK_DIV_STEP 8'h01
`define ADM_CLK_COUNT_W 16
`define ADM_CLK_COUNT_ZERO 16'h0000
`define ADM_CLK_COUNT_STEP 16'h0001

// Analog comparator inputs, synchronised as one vector
`define ADM_ASYNC_W 8
`define ADM_ASYNC_ZERO 8'h00
`define ADM_ASYNC_REF_BELOW 0
`define ADM_ASYNC_REF_POS_OPEN 1
`define ADM_ASYNC_REF_NEG_OPEN 2
`define ADM_ASYNC_POS_RANGE 3
`define ADM_ASYNC_NEG_RANGE 4
`define ADM_ASYNC_REF_POS_HIGH 5
`define ADM_ASYNC_REF_NEG_LOW 6
`define ADM_ASYNC_STANDBY 7

`endif

// file: rtl/adm_error_monitor.v
/*
 * ADC diagnostic error monitor: reference loss, conversion and calibration
 * errors, input and reference range flags, test and supply input selection,
 * and the controller clock counter, with a simple register port.
 * Assumes analog comparators drive asynchronous levels, and that the
 * modulator, filter and calibration logic run on CORE_CLK.
 */
// Added by the designer: the address map and strobed register access.
`default_nettype none
`include "adm_map.vh"

// How it works
// - Flag reference loss on low or open external reference
// - Reference loss also raises summary error bit
// - Conversion flag and offset discard only when enabled
// - Filter overflow flags error, clamps result
// - Twenty identical modulator bits flag error
// - Out-of-range offset coefficient discarded, flagged
// - Gain calibration overflow discards gain, flags
// - Conversion flag updates with data or calibration result, W1C
// - Separate enables and flags per analog input
// - One reference range flag for both pins
// - Range flags set when enabled, W1C
// - Supply selection routes supply through divide-by-six
// - Test code applies internal test signal
// - Clock count steps once per 131 cycles
// - Clock count wraps to zero
module adm_error_monitor (
  input wire CORE_CLK,
  input wire RESET_N,
  input wire [`ADM_ADDR_W-1:0] REG_ADDR,
  input wire [31:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [31:0] REG_RDATA,
  input wire REF_BELOW_THRESHOLD,
  input wire REF_POS_OPEN,
  input wire REF_NEG_OPEN,
  input wire POS_INPUT_OUT_OF_RANGE,
  input wire NEG_INPUT_OUT_OF_RANGE,
  input wire REF_POS_ABOVE_SUPPLY,
  input wire REF_NEG_BELOW_SUPPLY,
  input wire STANDBY_EXIT,
  input wire MOD_BIT,
  input wire MOD_BIT_VALID,
  input wire [`ADM_DATA_W-1:0] FILTER_RESULT,
  input wire FILTER_VALID,
  input wire FILTER_OVERFLOW,
  input wire FILTER_UNDERFLOW,
  input wire OFFSET_CAL_DONE,
  input wire [`ADM_DATA_W-1:0] OFFSET_CAL_COEFF,
  input wire GAIN_CAL_DONE,
  input wire [`ADM_DATA_W-1:0] GAIN_CAL_COEFF,
  input wire GAIN_CAL_OVERFLOW,
  output reg EXTERNAL_REFERENCE_SELECT,
  output reg SUPPLY_AVDD_SELECT,
  output reg SUPPLY_IOVDD_SELECT,
  output reg SUPPLY_ATTENUATOR_ENABLE,
  output reg TEST_SIGNAL_POSITIVE_SELECT,
  output reg TEST_SIGNAL_NEGATIVE_SELECT,
  output reg [`ADM_DATA_W-1:0] CONVERSION_DATA,
  output reg [`ADM_DATA_W-1:0] OFFSET_COEFF,
  output reg [`ADM_DATA_W-1:0] GAIN_COEFF,
  output reg ERROR_SUMMARY
);

  reg [`ADM_EN_W-1:0] enable_r;
  reg [`ADM_FLAG_W-1:0] flags_r;
  reg [`ADM_FLAG_W-1:0] flags_nxt;
  reg [`ADM_SEL_W-1:0] chan_sel_r;
  reg [`ADM_ASYNC_W-1:0] sync1_r;
  reg [`ADM_ASYNC_W-1:0] sync2_r;
  reg [`ADM_RUN_W-1:0] run_cnt_r;
  reg [`ADM_RUN_W-1:0] run_cnt_nxt;
  reg last_bit_r;
  reg sat_pending_r;
  reg sat_pending_nxt;
  reg [`ADM_CLK_DIV_W-1:0] div_r;
  reg [`ADM_CLK_COUNT_W-1:0] clk_count_r;
  reg [`ADM_FLAG_W-1:0] clear_mask;
  reg [`ADM_FLAG_W-1:0] set_mask;
  reg [31:0] rd_nxt;

  wire [`ADM_ASYNC_W-1:0] async_in;
  wire ref_below_s;
  wire ref_pos_open_s;
  wire ref_neg_open_s;
  wire pos_range_s;
  wire neg_range_s;
  wire ref_pos_high_s;
  wire ref_neg_low_s;
  wire standby_exit_s;
  wire conv_en;
  wire offset_bad;
  wire div_tick;
  wire [1:0] sel_code;
  wire offset_drop;
  wire ref_loss_cond;
  wire filter_fault;
  wire cal_fault;
  wire flag_wr;
  wire offset_wr;
  wire gain_wr;

  // Comparator levels gathered for one synchroniser
  assign async_in = {STANDBY_EXIT, REF_NEG_BELOW_SUPPLY, REF_POS_ABOVE_SUPPLY,
                     NEG_INPUT_OUT_OF_RANGE, POS_INPUT_OUT_OF_RANGE,
                     REF_NEG_OPEN, REF_POS_OPEN, REF_BELOW_THRESHOLD};

  // Two-stage synchroniser for the comparator levels
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync1_r <= `ADM_ASYNC_ZERO;
      sync2_r <= `ADM_ASYNC_ZERO;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end

  // Synchronised condition names
  assign ref_below_s = sync2_r[`ADM_ASYNC_REF_BELOW];
  assign ref_pos_open_s = sync2_r[`ADM_ASYNC_REF_POS_OPEN];
  assign ref_neg_open_s = sync2_r[`ADM_ASYNC_REF_NEG_OPEN];
  assign pos_range_s = sync2_r[`ADM_ASYNC_POS_RANGE];
  assign neg_range_s = sync2_r[`ADM_ASYNC_NEG_RANGE];
  assign ref_pos_high_s = sync2_r[`ADM_ASYNC_REF_POS_HIGH];
  assign ref_neg_low_s = sync2_r[`ADM_ASYNC_REF_NEG_LOW];
  assign standby_exit_s = sync2_r[`ADM_ASYNC_STANDBY];

  // Decoded enables, channel code and offset range test
  assign conv_en = enable_r[`ADM_EN_CONV];
  assign sel_code = chan_sel_r[`ADM_SEL_CODE_HI:`ADM_SEL_CODE_LO];
  assign offset_bad = (OFFSET_CAL_COEFF < `ADM_OFFSET_MIN) ||
                      (OFFSET_CAL_COEFF > `ADM_OFFSET_MAX);

  // An out-of-range offset result is dropped only while checks run
  assign offset_drop = conv_en && offset_bad;

  // Reference loss: low differential or either reference pin open
  assign ref_loss_cond = ref_below_s || ref_pos_open_s || ref_neg_open_s;

  // Filter range faults and pending saturation commit with a data update
  assign filter_fault = FILTER_VALID &&
                        (FILTER_OVERFLOW || FILTER_UNDERFLOW || sat_pending_r);

  // Calibration faults: offset out of range or gain overflow
  assign cal_fault = (OFFSET_CAL_DONE && offset_bad) ||
                     (GAIN_CAL_DONE && GAIN_CAL_OVERFLOW);

  // Host write decodes
  assign flag_wr = REG_WR && (REG_ADDR == `ADM_OFF_ERR_FLAGS);
  assign offset_wr = REG_WR && (REG_ADDR == `ADM_OFF_OFFSET);
  assign gain_wr = REG_WR && (REG_ADDR == `ADM_OFF_GAIN);

  // Modulator run length of identical bits
  always @* begin
    run_cnt_nxt = run_cnt_r;
    if (MOD_BIT_VALID) begin
      if (MOD_BIT == last_bit_r && run_cnt_r != `ADM_RUN_ZERO) begin
        if (run_cnt_r < `ADM_RUN_LIMIT) begin
          run_cnt_nxt = run_cnt_r + `ADM_RUN_ONE;
        end
      end else begin
        run_cnt_nxt = `ADM_RUN_ONE;
      end
    end
  end

  // Saturation is held until the next data update commits it
  always @* begin
    sat_pending_nxt = sat_pending_r;
    if (FILTER_VALID) begin
      sat_pending_nxt = 1'b0;
    end
    if (MOD_BIT_VALID && conv_en && run_cnt_nxt == `ADM_RUN_LIMIT) begin
      sat_pending_nxt = 1'b1;
    end
  end

  // Hardware set events for each flag
  always @* begin
    set_mask = `ADM_FLAG_RESET;
    set_mask[`ADM_FLAG_REF_LOSS] = enable_r[`ADM_EN_REF_LOSS] &&
      chan_sel_r[`ADM_SEL_EXT_REF] && ref_loss_cond;
    set_mask[`ADM_FLAG_CONV] = conv_en && (filter_fault || cal_fault);
    set_mask[`ADM_FLAG_POS_IN] = enable_r[`ADM_EN_POS_IN] && pos_range_s;
    set_mask[`ADM_FLAG_NEG_IN] = enable_r[`ADM_EN_NEG_IN] && neg_range_s;
    set_mask[`ADM_FLAG_REF_RANGE] = enable_r[`ADM_EN_REF_RANGE] &&
      (ref_pos_high_s || ref_neg_low_s);
  end

  // Write-one-to-clear, with a same-cycle set taking priority
  always @* begin
    clear_mask = `ADM_FLAG_RESET;
    if (flag_wr) begin
      clear_mask = REG_WDATA[`ADM_FLAG_W-1:0];
    end
    flags_nxt = (flags_r & ~clear_mask) | set_mask;
  end

  // Flags, summary bit and modulator tracking
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      flags_r <= `ADM_FLAG_RESET;
      ERROR_SUMMARY <= 1'b0;
      run_cnt_r <= `ADM_RUN_ZERO;
      last_bit_r <= 1'b0;
      sat_pending_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      ERROR_SUMMARY <= |flags_nxt;
      run_cnt_r <= run_cnt_nxt;
      if (MOD_BIT_VALID) begin
        last_bit_r <= MOD_BIT;
      end
      sat_pending_r <= sat_pending_nxt;
    end
  end

  // Conversion result with clamp on filter range faults
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CONVERSION_DATA <= `ADM_DATA_ZERO;
    end else if (FILTER_VALID) begin
      if (FILTER_OVERFLOW) begin
        CONVERSION_DATA <= `ADM_DATA_ONES;
      end else if (FILTER_UNDERFLOW) begin
        CONVERSION_DATA <= `ADM_DATA_ZERO;
      end else begin
        CONVERSION_DATA <= FILTER_RESULT;
      end
    end
  end

  // Calibration coefficients; host writes and good results load them
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      OFFSET_COEFF <= `ADM_OFFSET_RESET;
      GAIN_COEFF <= `ADM_GAIN_RESET;
    end else begin
      if (OFFSET_CAL_DONE) begin
        if (!offset_drop) begin
          OFFSET_COEFF <= OFFSET_CAL_COEFF;
        end
      end else if (offset_wr) begin
        OFFSET_COEFF <= REG_WDATA[`ADM_DATA_W-1:0];
      end
      if (GAIN_CAL_DONE) begin
        if (!GAIN_CAL_OVERFLOW) begin
          GAIN_COEFF <= GAIN_CAL_COEFF;
        end
      end else if (gain_wr) begin
        GAIN_COEFF <= REG_WDATA[`ADM_DATA_W-1:0];
      end
    end
  end

  // Enable and channel select registers
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      enable_r <= `ADM_EN_RESET;
      chan_sel_r <= `ADM_SEL_RESET;
    end else if (REG_WR) begin
      if (REG_ADDR == `ADM_OFF_ERR_EN) begin
        enable_r <= REG_WDATA[`ADM_EN_W-1:0];
      end
      if (REG_ADDR == `ADM_OFF_CHAN_SEL) begin
        chan_sel_r <= REG_WDATA[`ADM_SEL_W-1:0];
      end
    end
  end

  // Analog routing controls decoded from the channel select
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      EXTERNAL_REFERENCE_SELECT <= 1'b0;
      SUPPLY_AVDD_SELECT <= 1'b0;
      SUPPLY_IOVDD_SELECT <= 1'b0;
      SUPPLY_ATTENUATOR_ENABLE <= 1'b0;
      TEST_SIGNAL_POSITIVE_SELECT <= 1'b0;
      TEST_SIGNAL_NEGATIVE_SELECT <= 1'b0;
    end else begin
      EXTERNAL_REFERENCE_SELECT <= chan_sel_r[`ADM_SEL_EXT_REF];
      SUPPLY_AVDD_SELECT <= (sel_code == `ADM_CODE_AVDD);
      SUPPLY_IOVDD_SELECT <= (sel_code == `ADM_CODE_IOVDD);
      SUPPLY_ATTENUATOR_ENABLE <= (sel_code == `ADM_CODE_AVDD) ||
                                  (sel_code == `ADM_CODE_IOVDD);
      TEST_SIGNAL_POSITIVE_SELECT <= (sel_code == `ADM_CODE_TEST);
      TEST_SIGNAL_NEGATIVE_SELECT <= (sel_code == `ADM_CODE_TEST);
    end
  end

  // Divider wraps after its last count
  assign div_tick = (div_r == `ADM_CLK_DIV_LAST);

  // Controller clock counter: one step per 131 cycles, wrapping
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_r <= `ADM_CLK_DIV_ZERO;
      clk_count_r <= `ADM_CLK_COUNT_ZERO;
    end else if (enable_r[`ADM_EN_CLK_COUNT]) begin
      if (div_tick) begin
        div_r <= `ADM_CLK_DIV_ZERO;
        clk_count_r <= clk_count_r + `ADM_CLK_COUNT_STEP;
      end else begin
        div_r <= div_r + `ADM_CLK_DIV_STEP;
      end
    end
  end

  // Read mux; unmapped offsets read as zero
  always @* begin
    rd_nxt = `ADM_WORD_ZERO;
    case (REG_ADDR)
      `ADM_OFF_ERR_EN: rd_nxt[`ADM_EN_W-1:0] = enable_r;
      `ADM_OFF_ERR_FLAGS: rd_nxt[`ADM_FLAG_W-1:0] = flags_r;
      `ADM_OFF_STATUS: rd_nxt[`ADM_STAT_SUMMARY] = ERROR_SUMMARY;
      `ADM_OFF_CLK_COUNT: rd_nxt[`ADM_CLK_COUNT_W-1:0] = clk_count_r;
      `ADM_OFF_CHAN_SEL: rd_nxt[`ADM_SEL_W-1:0] = chan_sel_r;
      `ADM_OFF_OFFSET: rd_nxt[`ADM_DATA_W-1:0] = OFFSET_COEFF;
      `ADM_OFF_GAIN: rd_nxt[`ADM_DATA_W-1:0] = GAIN_COEFF;
      `ADM_OFF_DATA: rd_nxt[`ADM_DATA_W-1:0] = CONVERSION_DATA;
      default: rd_nxt = `ADM_WORD_ZERO;
    endcase
  end

  // Read data stands one cycle after the strobe only
  always @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA <= `ADM_WORD_ZERO;
    end else if (REG_RD) begin
      REG_RDATA <= rd_nxt;
    end else begin
      REG_RDATA <= `ADM_WORD_ZERO;
    end
  end

  // Standby exit is only observed so it passes the synchroniser cleanly
  wire unused_standby;
  assign unused_standby = standby_exit_s;

endmodule // adm_error_monitor
`default_nettype wire

// file: rtl/adm_unused_placeholder.v
/*
 * Intentionally empty companion file; holds no logic.
 * Assumes nothing.
 */
`default_nettype none
`default_nettype wire

// file: dv/adm_chk.sv
/* Port checker of the error monitor.
   Assumes it is bound into every instance of the monitor. */
`default_nettype none
module adm_chk (
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic [23:0] FILTER_RESULT,
  input wire logic FILTER_VALID,
  input wire logic FILTER_OVERFLOW,
  input wire logic FILTER_UNDERFLOW,
  input wire logic GAIN_CAL_DONE,
  input wire logic GAIN_CAL_OVERFLOW,
  input wire logic SUPPLY_AVDD_SELECT,
  input wire logic SUPPLY_IOVDD_SELECT,
  input wire logic SUPPLY_ATTENUATOR_ENABLE,
  input wire logic TEST_SIGNAL_POSITIVE_SELECT,
  input wire logic TEST_SIGNAL_NEGATIVE_SELECT,
  input wire logic [23:0] CONVERSION_DATA,
  input wire logic [23:0] GAIN_COEFF,
  input wire logic ERROR_SUMMARY
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // Summary holds until the host writes the flag register
  sum_hold_a: assert property (
    ERROR_SUMMARY && !(REG_WR && REG_ADDR == 8'h04) |=> ERROR_SUMMARY)
    else $error("summary dropped");
  // Status read returns the summary bit seen at the strobe
  stat_read_a: assert property (
    REG_RD && REG_ADDR == 8'h08 |=> REG_RDATA == {31'h0, $past(ERROR_SUMMARY)})
    else $error("status read wrong");
  // Result register follows the filter, clamped on overflow or underflow; gain kept on overflow
  ovf_clamp_a: assert property (
    FILTER_VALID && FILTER_OVERFLOW |=> CONVERSION_DATA == 24'hffffff)
    else $error("no clamp to ones");
  unf_clamp_a: assert property (
    FILTER_VALID && !FILTER_OVERFLOW && FILTER_UNDERFLOW |=> CONVERSION_DATA == 24'h000000)
    else $error("no clamp to zeros");
  data_load_a: assert property (
    FILTER_VALID && !FILTER_OVERFLOW && !FILTER_UNDERFLOW
    |=> CONVERSION_DATA == $past(FILTER_RESULT))
    else $error("result not loaded");
  data_hold_a: assert property (!FILTER_VALID |=> $stable(CONVERSION_DATA))
    else $error("result changed alone");
  gain_keep_a: assert property (
    GAIN_CAL_DONE && GAIN_CAL_OVERFLOW |=> $stable(GAIN_COEFF))
    else $error("gain loaded on overflow");
  // Input routing stays consistent
  atten_sel_a: assert property (
    SUPPLY_ATTENUATOR_ENABLE == (SUPPLY_AVDD_SELECT || SUPPLY_IOVDD_SELECT))
    else $error("attenuator mismatch");
  test_pair_a: assert property (
    TEST_SIGNAL_POSITIVE_SELECT == TEST_SIGNAL_NEGATIVE_SELECT &&
    !(TEST_SIGNAL_POSITIVE_SELECT && SUPPLY_ATTENUATOR_ENABLE))
    else $error("test pair split");
endmodule // adm_chk
bind adm_error_monitor adm_chk u_chk (
  .CORE_CLK(CORE_CLK),
  .RESET_N(RESET_N),
  .REG_ADDR(REG_ADDR),
  .REG_WR(REG_WR),
  .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA),
  .FILTER_RESULT(FILTER_RESULT),
  .FILTER_VALID(FILTER_VALID),
  .FILTER_OVERFLOW(FILTER_OVERFLOW),
  .FILTER_UNDERFLOW(FILTER_UNDERFLOW),
  .GAIN_CAL_DONE(GAIN_CAL_DONE),
  .GAIN_CAL_OVERFLOW(GAIN_CAL_OVERFLOW),
  .SUPPLY_AVDD_SELECT(SUPPLY_AVDD_SELECT),
  .SUPPLY_IOVDD_SELECT(SUPPLY_IOVDD_SELECT),
  .SUPPLY_ATTENUATOR_ENABLE(SUPPLY_ATTENUATOR_ENABLE),
  .TEST_SIGNAL_POSITIVE_SELECT(TEST_SIGNAL_POSITIVE_SELECT),
  .TEST_SIGNAL_NEGATIVE_SELECT(TEST_SIGNAL_NEGATIVE_SELECT),
  .CONVERSION_DATA(CONVERSION_DATA),
  .GAIN_COEFF(GAIN_COEFF),
  .ERROR_SUMMARY(ERROR_SUMMARY)
);
`default_nettype wire

// file: dv/adm_host_model.sv
/* Host processor model on the register port.
   Assumes read data stand the cycle after the strobe. */
`default_nettype none
module adm_host_model (
  input wire logic CORE_CLK,
  output logic [7:0] REG_ADDR,
  output logic [31:0] REG_WDATA,
  output logic REG_WR,
  output logic REG_RD,
  input wire logic [31:0] REG_RDATA
);
  timeunit 1ns;
  timeprecision 1ns;
  // Port idle at time zero
  initial {REG_ADDR, REG_WDATA, REG_WR, REG_RD} = '0;
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask
  // Read strobe for one cycle, data taken at the edge after it drops
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CORE_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    @(posedge CORE_CLK);
    d = REG_RDATA;
  endtask
  // Write ones to clear flags
  task automatic clr(input logic [4:0] m);
    wr(8'h04, {27'h0, m});
  endtask
  // Count difference over exactly n cycles
  task automatic rate(input int n, output logic [15:0] diff);
    logic [31:0] a, b;
    rd(8'h0c, a);
    repeat (n - 3) @(posedge CORE_CLK);
    rd(8'h0c, b);
    diff = b[15:0] - a[15:0];
  endtask
endmodule // adm_host_model
`default_nettype wire

// file: dv/adm_error_monitor_test.sv
/* Self-checking bench of the error monitor.
   Assumes the monitor, checker and host model are compiled first. */
`default_nettype none
module adm_error_monitor_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic CORE_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [7:0] REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA;
  logic REG_WR, REG_RD, STANDBY_EXIT = 1'b0;
  logic [6:0] cmp = 7'h00;
  logic REF_BELOW_THRESHOLD, REF_POS_OPEN, REF_NEG_OPEN, POS_INPUT_OUT_OF_RANGE;
  logic NEG_INPUT_OUT_OF_RANGE, REF_POS_ABOVE_SUPPLY, REF_NEG_BELOW_SUPPLY;
  logic MOD_BIT = 1'b0, MOD_BIT_VALID = 1'b0, FILTER_VALID = 1'b0;
  logic FILTER_OVERFLOW = 1'b0, FILTER_UNDERFLOW = 1'b0, OFFSET_CAL_DONE = 1'b0;
  logic GAIN_CAL_DONE = 1'b0, GAIN_CAL_OVERFLOW = 1'b0;
  logic [23:0] FILTER_RESULT = 24'h0, OFFSET_CAL_COEFF = 24'h0, GAIN_CAL_COEFF = 24'h0;
  logic EXTERNAL_REFERENCE_SELECT, SUPPLY_AVDD_SELECT, SUPPLY_IOVDD_SELECT;
  logic SUPPLY_ATTENUATOR_ENABLE, TEST_SIGNAL_POSITIVE_SELECT, TEST_SIGNAL_NEGATIVE_SELECT;
  logic [23:0] CONVERSION_DATA, OFFSET_COEFF, GAIN_COEFF;
  logic ERROR_SUMMARY;
  logic [5:0] route;
  int num_checks = 0;
  int miscompares = 0;
  // Comparator levels from one vector
  assign {REF_NEG_BELOW_SUPPLY, REF_POS_ABOVE_SUPPLY, NEG_INPUT_OUT_OF_RANGE,
    POS_INPUT_OUT_OF_RANGE, REF_NEG_OPEN, REF_POS_OPEN, REF_BELOW_THRESHOLD} = cmp;
  assign route = {EXTERNAL_REFERENCE_SELECT, SUPPLY_AVDD_SELECT, SUPPLY_IOVDD_SELECT,
    SUPPLY_ATTENUATOR_ENABLE, TEST_SIGNAL_POSITIVE_SELECT, TEST_SIGNAL_NEGATIVE_SELECT};
  adm_error_monitor dut (
    .CORE_CLK(CORE_CLK),
    .RESET_N(RESET_N),
    .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR),
    .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA),
    .REF_BELOW_THRESHOLD(REF_BELOW_THRESHOLD),
    .REF_POS_OPEN(REF_POS_OPEN),
    .REF_NEG_OPEN(REF_NEG_OPEN),
    .POS_INPUT_OUT_OF_RANGE(POS_INPUT_OUT_OF_RANGE),
    .NEG_INPUT_OUT_OF_RANGE(NEG_INPUT_OUT_OF_RANGE),
    .REF_POS_ABOVE_SUPPLY(REF_POS_ABOVE_SUPPLY),
    .REF_NEG_BELOW_SUPPLY(REF_NEG_BELOW_SUPPLY),
    .STANDBY_EXIT(STANDBY_EXIT),
    .MOD_BIT(MOD_BIT),
    .MOD_BIT_VALID(MOD_BIT_VALID),
    .FILTER_RESULT(FILTER_RESULT),
    .FILTER_VALID(FILTER_VALID),
    .FILTER_OVERFLOW(FILTER_OVERFLOW),
    .FILTER_UNDERFLOW(FILTER_UNDERFLOW),
    .OFFSET_CAL_DONE(OFFSET_CAL_DONE),
    .OFFSET_CAL_COEFF(OFFSET_CAL_COEFF),
    .GAIN_CAL_DONE(GAIN_CAL_DONE),
    .GAIN_CAL_COEFF(GAIN_CAL_COEFF),
    .GAIN_CAL_OVERFLOW(GAIN_CAL_OVERFLOW),
    .EXTERNAL_REFERENCE_SELECT(EXTERNAL_REFERENCE_SELECT),
    .SUPPLY_AVDD_SELECT(SUPPLY_AVDD_SELECT),
    .SUPPLY_IOVDD_SELECT(SUPPLY_IOVDD_SELECT),
    .SUPPLY_ATTENUATOR_ENABLE(SUPPLY_ATTENUATOR_ENABLE),
    .TEST_SIGNAL_POSITIVE_SELECT(TEST_SIGNAL_POSITIVE_SELECT),
    .TEST_SIGNAL_NEGATIVE_SELECT(TEST_SIGNAL_NEGATIVE_SELECT),
    .CONVERSION_DATA(CONVERSION_DATA),
    .OFFSET_COEFF(OFFSET_COEFF),
    .GAIN_COEFF(GAIN_COEFF),
    .ERROR_SUMMARY(ERROR_SUMMARY)
  );
  adm_host_model host (
    .CORE_CLK(CORE_CLK),
    .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR),
    .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA)
  );
  always #4 CORE_CLK = ~CORE_CLK;
  // Compare and count
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    host.rd(a, d);
    chk($sformatf("reg %h", a), d, e);
  endtask
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask
  // One filter result with its error levels
  task automatic fv(input logic o, input logic u, input logic [23:0] r);
    cyc(1);
    FILTER_VALID <= 1'b1;
    FILTER_OVERFLOW <= o;
    FILTER_UNDERFLOW <= u;
    FILTER_RESULT <= r;
    cyc(1);
    FILTER_VALID <= 1'b0;
    cyc(1);
  endtask
  // Run of n valid modulator bits
  task automatic mod(input int n, input logic b);
    repeat (n) begin
      cyc(1);
      MOD_BIT <= b;
      MOD_BIT_VALID <= 1'b1;
    end
    cyc(1);
    MOD_BIT_VALID <= 1'b0;
  endtask
  // Offset or gain calibration result
  task automatic cal(input logic g, input logic ov, input logic [23:0] c);
    cyc(1);
    OFFSET_CAL_DONE <= !g;
    GAIN_CAL_DONE <= g;
    GAIN_CAL_OVERFLOW <= ov;
    OFFSET_CAL_COEFF <= c;
    GAIN_CAL_COEFF <= c;
    cyc(1);
    OFFSET_CAL_DONE <= 1'b0;
    GAIN_CAL_DONE <= 1'b0;
    cyc(1);
  endtask
  task automatic t_reset;
    rc(8'h00, 32'h0);
    chk("offset", OFFSET_COEFF, 24'h800000);
    chk("gain", GAIN_COEFF, 24'h555555);
    rc(8'h40, 32'h0);
  endtask
  task automatic t_sel;
    logic [5:0] ex [4] = '{6'h00, 6'h14, 6'h0c, 6'h23};
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h10, (i == 3) ? 32'h13 : i);
      cyc(2);
      chk("routing", route, ex[i]);
    end
  endtask
  // Each comparator raises its flag (three share ref loss, two ref range), which holds until cleared
  task automatic t_flags;
    logic [4:0] ef [7] = '{5'h01, 5'h01, 5'h01, 5'h04, 5'h08, 5'h10, 5'h10};
    host.wr(8'h10, 32'h10);
    host.wr(8'h00, 32'h1d);
    for (int i = 0; i < 7; i++) begin
      cyc(1);
      cmp <= 7'h01 << i;
      cyc(4);
      cmp <= 7'h00;
      cyc(4);
      rc(8'h04, ef[i]);
      rc(8'h08, 32'h1);
      host.clr(ef[i]);
      rc(8'h04, 32'h0);
      chk("summary", ERROR_SUMMARY, 32'h0);
    end
    host.wr(8'h10, 32'h00);
    host.wr(8'h00, 32'h01);
    cmp <= 7'h7f;
    cyc(6);
    cmp <= 7'h00;
    rc(8'h04, 32'h0);
  endtask
  task automatic t_conv;
    host.wr(8'h00, 32'h02);
    fv(1'b1, 1'b0, 24'h123456);
    chk("data", CONVERSION_DATA, 24'hffffff);
    rc(8'h04, 32'h02);
    host.clr(5'h02);
    fv(1'b0, 1'b1, 24'h123456);
    chk("data", CONVERSION_DATA, 24'h000000);
    rc(8'h04, 32'h02);
    host.clr(5'h02);
    mod(19, 1'b1);
    mod(1, 1'b0);
    fv(1'b0, 1'b0, 24'h123456);
    chk("data", CONVERSION_DATA, 24'h123456);
    rc(8'h04, 32'h0);
    mod(20, 1'b1);
    fv(1'b0, 1'b0, 24'h000001);
    rc(8'h04, 32'h02);
    host.clr(5'h02);
    host.wr(8'h00, 32'h00);
    fv(1'b1, 1'b0, 24'h000001);
    chk("data", CONVERSION_DATA, 24'hffffff);
    rc(8'h04, 32'h0);
  endtask
  task automatic t_cal;
    host.wr(8'h00, 32'h02);
    cal(1'b0, 1'b0, 24'h07fffe);
    chk("offset", OFFSET_COEFF, 24'h800000);
    rc(8'h04, 32'h02);
    host.clr(5'h02);
    cal(1'b0, 1'b0, 24'hf7ffff);
    chk("offset", OFFSET_COEFF, 24'hf7ffff);
    cal(1'b1, 1'b1, 24'h000001);
    chk("gain", GAIN_COEFF, 24'h555555);
    rc(8'h04, 32'h02);
    host.clr(5'h02);
    cal(1'b1, 1'b0, 24'h2aaaaa);
    chk("gain", GAIN_COEFF, 24'h2aaaaa);
    rc(8'h04, 32'h0);
    cal(1'b0, 1'b0, 24'h07ffff);
    chk("offset", OFFSET_COEFF, 24'h07ffff);
    cal(1'b0, 1'b0, 24'hf80000);
    chk("offset", OFFSET_COEFF, 24'h07ffff);
    rc(8'h04, 32'h02);
  endtask
  task automatic t_cnt;
    logic [15:0] d;
    host.wr(8'h00, 32'h20);
    host.rate(393, d);
    chk("count step", d, 32'h3);
    host.wr(8'h00, 32'h00);
    host.rate(262, d);
    chk("count hold", d, 32'h0);
  endtask
  // Main sequence after reset
  initial begin
    cyc(3);
    RESET_N <= 1'b1;
    t_reset;
    t_sel;
    t_flags;
    t_conv;
    t_cal;
    t_cnt;
    print_verdict;
  end
  // Hang guard
  initial begin
    cyc(20000);
    miscompares++;
    print_verdict;
  end
endmodule // adm_error_monitor_test
`default_nettype wire
